// ==== sensor_host_register_bank.sv ====
// Host register bank: extended access, special actions, status and faults
module sensor_host_register_bank
   import sensor_regs_pkg::*;
#(
   parameter int unsigned NVM_WR_CYC = NVM_WR_CYC_DEF,
   parameter int unsigned ACTION_CYC = ACTION_CYC_DEF
) (
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        SRST,
   // Register port
   input  wire logic [5:0]  REG_ADDR,
   input  wire logic        REG_WE,
   input  wire logic        REG_RE,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   output logic             REG_RVALID,
   // Angle datapath and monitors
   input  wire logic [11:0] ANGLE,
   input  wire logic        PLL_LOCK,
   input  wire logic        ROT_DIR,
   input  wire logic [1:0]  DIE_ID,
   input  wire logic        BOOT_BUSY,
   input  wire logic        BOOT_DONE,
   input  wire logic        UV_ANALOG,
   input  wire logic        UV_DIGITAL,
   input  wire logic        NVM_WRITE_FAIL,
   // Event and shadow mask vectors
   input  wire logic [15:0] FAULT_EVENTS,
   input  wire logic [15:0] WARN_EVENTS,
   input  wire logic [15:0] ERR_MASK,
   input  wire logic [15:0] WARN_MASK
);

   // Storage: nvm words 0..31, shadow words 32..63
   logic [31:0] mem [0:63];

   // Host-written registers and fetched halves
   logic [7:0]  wr_addr_q;      // Extended write target
   logic [15:0] pay_upper_q;    // payload_upper_half
   logic [15:0] pay_lower_q;    // payload_lower_half
   logic [7:0]  rd_addr_q;      // Extended read source
   logic [15:0] fet_upper_q;    // fetched_upper_half
   logic [15:0] fet_lower_q;    // fetched_lower_half
   // Engine state
   logic        wdn_q, rdn_q;   // Finished flags
   logic [5:0]  wr_idx_q, rd_idx_q;
   logic        wr_bad_q;       // Write doomed: locked or unmapped
   logic        rd_ok_q;        // Read source mapped
   logic [31:0] wr_data_q;      // Payload snapshot
   logic        wip, rip, wr_done, rd_done;
   // Special action state and boot done flag
   logic [3:0]  special_q;      // Running action, zero when idle
   logic        sdn_q, bdn_q;
   logic        act_busy, act_done;
   // Lock state
   logic [2:0]  key_step_q;
   logic        unlocked_q;
   // Latched flags and the bits host has seen
   logic [10:0] fault_q, fault_seen_q;
   logic [11:0] warn_q, warn_seen_q;

   // Decoded host strobes
   logic        wr_start, rd_start, overrun, act_start, hreset;
   logic [7:0]  trig;
   logic [3:0]  spec_req;
   logic        uv_live, war, fsum;
   logic [15:0] pos_word, rd_mux;
   logic [TMR_W-1:0] wr_len, rd_len;

   // Target classification for both engines
   function automatic logic is_nvm(input logic [7:0] a);
      is_nvm = (a[7:5] == 3'b000);
   endfunction
   function automatic logic is_shadow(input logic [7:0] a);
      is_shadow = (a[7:5] == 3'b010);
   endfunction

   // Trigger and unlock gate for a requested action
   function automatic logic action_ok(input logic [3:0] f,
                                      input logic [7:0] t,
                                      input logic       unl);
      case (f)
         ACT_MARGLO, ACT_MARGHI: action_ok = (t == TRIG_NVM);
         ACT_RELOAD:             action_ok = (t == TRIG_NVM) && unl;
         ACT_HRESET:             action_ok = (t == TRIG_RESET) && unl;
         ACT_FE_ST, ACT_LOG_ST,
         ACT_BOTH:               action_ok = (t == TRIG_SELFTEST);
         default:                action_ok = 1'b0;
      endcase
   endfunction

   // Start strobes; a start during any busy access is dropped
   assign wr_start = REG_WE && (REG_ADDR == OFS_WR_CTRL) &&
                     REG_WDATA[START_BIT] && !overrun;
   assign rd_start = REG_WE && (REG_ADDR == OFS_RD_CTRL) &&
                     REG_WDATA[START_BIT] && !overrun;
   assign overrun  = REG_WE && REG_WDATA[START_BIT] && (wip || rip) &&
                     ((REG_ADDR == OFS_WR_CTRL) || (REG_ADDR == OFS_RD_CTRL));
   assign trig     = REG_WDATA[7:0];
   assign spec_req = REG_WDATA[SPECIAL_LSB +: 4];
   assign act_start = REG_WE && (REG_ADDR == OFS_COMMAND) && !act_busy &&
                      action_ok(spec_req, trig, unlocked_q);
   assign hreset    = act_done && (special_q == ACT_HRESET);

   // Write doomed; lock state passed in so the length tracks unlocking
   function automatic logic wr_bad_start(input logic [7:0] a,
                                         input logic       unl);
      wr_bad_start = !unl || !(is_nvm(a) || is_shadow(a));
   endfunction

   assign wr_len = (!wr_bad_start(wr_addr_q, unlocked_q) &&
                    is_nvm(wr_addr_q)) ?
                   TMR_W'(NVM_WR_CYC) : TMR_W'(SHADOW_CYC);
   assign rd_len = is_nvm(rd_addr_q) ? TMR_W'(NVM_RD_CYC) :
                   TMR_W'(SHADOW_CYC);

   // Timers for write, read and special action
   xfer_timer #(.W(TMR_W)) u_wr_tmr (
      .clk   (REF_CLK),
      .rst   (SRST),
      .start (wr_start),
      .len   (wr_len),
      .busy  (wip),
      .done  (wr_done)
   );
   xfer_timer #(.W(TMR_W)) u_rd_tmr (
      .clk   (REF_CLK),
      .rst   (SRST),
      .start (rd_start),
      .len   (rd_len),
      .busy  (rip),
      .done  (rd_done)
   );
   xfer_timer #(.W(TMR_W)) u_act_tmr (
      .clk   (REF_CLK),
      .rst   (SRST),
      .start (act_start),
      .len   (TMR_W'(ACTION_CYC)),
      .busy  (act_busy),
      .done  (act_done)
   );

   // Plain host registers; read address moves after reload, logic self-test or combined self-test
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         wr_addr_q   <= 8'h00;
         pay_upper_q <= 16'h0000;
         pay_lower_q <= 16'h0000;
         rd_addr_q   <= 8'h00;
      end else begin
         if (REG_WE && REG_ADDR == OFS_WR_ADDR)  wr_addr_q   <= REG_WDATA[7:0];
         if (REG_WE && REG_ADDR == OFS_WR_UPPER) pay_upper_q <= REG_WDATA;
         if (REG_WE && REG_ADDR == OFS_WR_LOWER) pay_lower_q <= REG_WDATA;
         if (act_done && (special_q == ACT_RELOAD ||
                          special_q == ACT_LOG_ST || special_q == ACT_BOTH))
            rd_addr_q <= RD_ADDR_AFTER;
         else if (REG_WE && REG_ADDR == OFS_RD_ADDR)
            rd_addr_q <= REG_WDATA[7:0];
      end
   end

   // Extended write engine: snapshot at start, commit at finish
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         wdn_q     <= 1'b0;
         wr_bad_q  <= 1'b0;
         wr_idx_q  <= 6'h00;
         wr_data_q <= 32'h0000_0000;
      end else if (wr_start) begin
         wdn_q     <= 1'b0;
         wr_bad_q  <= wr_bad_start(wr_addr_q, unlocked_q);
         wr_idx_q  <= {wr_addr_q[6], wr_addr_q[4:0]};
         wr_data_q <= {pay_upper_q, pay_lower_q};
      end else if (wr_done) begin
         wdn_q <= 1'b1;
      end
   end

   // Memory commit; a locked or unmapped write never touches it
   always_ff @(posedge REF_CLK) begin
      if (wr_done && !wr_bad_q && !NVM_WRITE_FAIL)
         mem[wr_idx_q] <= wr_data_q;
   end

   // Extended read engine; unmapped source fetches zero
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rdn_q       <= 1'b0;
         rd_ok_q     <= 1'b0;
         rd_idx_q    <= 6'h00;
         fet_upper_q <= 16'h0000;
         fet_lower_q <= 16'h0000;
      end else if (rd_start) begin
         rdn_q    <= 1'b0;
         rd_ok_q  <= is_nvm(rd_addr_q) || is_shadow(rd_addr_q);
         rd_idx_q <= {rd_addr_q[6], rd_addr_q[4:0]};
      end else if (rd_done) begin
         rdn_q       <= 1'b1;
         fet_upper_q <= rd_ok_q ? mem[rd_idx_q][31:16] : 16'h0000;
         fet_lower_q <= rd_ok_q ? mem[rd_idx_q][15:0]  : 16'h0000;
      end
   end

   // Special action field and completion flags
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         special_q <= ACT_NONE;
         sdn_q     <= 1'b0;
         bdn_q     <= 1'b0;
      end else begin
         if (act_start)
            special_q <= spec_req;
         else if (act_done)
            special_q <= ACT_NONE;
         if (act_start)
            sdn_q <= 1'b0;
         else if (act_done)
            sdn_q <= 1'b1;
         else if (REG_WE && REG_ADDR == OFS_COMMAND && REG_WDATA[CLR_STATUS])
            sdn_q <= 1'b0;
         if (BOOT_DONE)
            bdn_q <= 1'b1;
         else if (REG_WE && REG_ADDR == OFS_COMMAND && REG_WDATA[CLR_STATUS])
            bdn_q <= 1'b0;
      end
   end

   // Unlock key sequence; a hard reset locks the part again
   always_ff @(posedge REF_CLK) begin
      if (SRST || hreset) begin
         key_step_q <= 3'd0;
         unlocked_q <= 1'b0;
      end else if (REG_WE && REG_ADDR == OFS_KEY) begin
         if (REG_WDATA[KEY_LSB +: 8] == key_code(key_step_q)) begin
            if (key_step_q == 3'(KEY_LEN - 1)) begin
               unlocked_q <= 1'b1;
               key_step_q <= 3'd0;
            end else begin
               key_step_q <= key_step_q + 3'd1;
            end
         end else begin
            key_step_q <= (REG_WDATA[KEY_LSB +: 8] == key_code(3'd0)) ?
                          3'd1 : 3'd0;
         end
      end
   end

   // Fault latch: new events always win over a wipe in the same cycle
   always_ff @(posedge REF_CLK) begin
      logic [10:0] fset;
      fset = (FAULT_EVENTS[10:0] & FAULT_EV_MASK);
      fset[F_UVA] = fset[F_UVA] | UV_ANALOG;
      fset[F_UVD] = fset[F_UVD] | UV_DIGITAL;
      fset[F_RST] = hreset;
      if (SRST) begin
         fault_q      <= FAULT_RST_VAL;
         fault_seen_q <= 11'h000;
      end else if (REG_WE && REG_ADDR == OFS_COMMAND && REG_WDATA[CLR_FAULT]) begin
         fault_q      <= (fault_q & ~fault_seen_q) | fset;
         fault_seen_q <= 11'h000;
      end else begin
         fault_q <= fault_q | fset;
         if (REG_RE && REG_ADDR == OFS_FAULT)
            fault_seen_q <= fault_q;
      end
   end

   // Warning latch with overrun and failed-write events
   always_ff @(posedge REF_CLK) begin
      logic [11:0] wset;
      wset = WARN_EVENTS[11:0] & WARN_EV_MASK;
      wset[W_BSY] = overrun;
      wset[W_XEE] = wr_done && (wr_bad_q || NVM_WRITE_FAIL);
      if (SRST) begin
         warn_q      <= 12'h000;
         warn_seen_q <= 12'h000;
      end else if (REG_WE && REG_ADDR == OFS_COMMAND && REG_WDATA[CLR_WARN]) begin
         warn_q      <= (warn_q & ~warn_seen_q) | wset;
         warn_seen_q <= 12'h000;
      end else begin
         warn_q <= warn_q | wset;
         if (REG_RE && REG_ADDR == OFS_WARN)
            warn_seen_q <= warn_q;
      end
   end

   assign uv_live = (UV_ANALOG && !ERR_MASK[F_UVA]) ||
                    (UV_DIGITAL && !ERR_MASK[F_UVD]);
   assign war  = |(warn_q & ~WARN_MASK[11:0]) && !ERR_MASK[F_WAR];
   assign fsum = |(fault_q & ~ERR_MASK[10:0]) || war;
   assign pos_word = {1'b0, fsum, uv_live,
                      ~(^{fsum, uv_live, ANGLE}), ANGLE};

   // Read data selection; write-only fields read as zero
   always_comb begin
      rd_mux = 16'h0000;
      case (REG_ADDR)
         OFS_WR_ADDR:  rd_mux = {8'h00, wr_addr_q};
         OFS_WR_UPPER: rd_mux = pay_upper_q;
         OFS_WR_LOWER: rd_mux = pay_lower_q;
         OFS_WR_CTRL:  rd_mux = {7'h00, wip, 7'h00, wdn_q};
         OFS_RD_ADDR:  rd_mux = {8'h00, rd_addr_q};
         OFS_RD_CTRL:  rd_mux = {7'h00, rip, 7'h00, rdn_q};
         OFS_RD_UPPER: rd_mux = fet_upper_q;
         OFS_RD_LOWER: rd_mux = fet_lower_q;
         OFS_COMMAND:  rd_mux = {special_q, 12'h000};
         OFS_POSITION: rd_mux = pos_word;
         OFS_COND:     rd_mux = {COND_TAG, 2'b00, DIE_ID, ROT_DIR, 1'b0,
                                 sdn_q, bdn_q,
                                 (special_q == ACT_LOG_ST ||
                                  special_q == ACT_BOTH),
                                 (special_q == ACT_FE_ST ||
                                  special_q == ACT_BOTH),
                                 BOOT_BUSY, PLL_LOCK};
         OFS_FAULT:    rd_mux = {FAULT_TAG, war, fault_q};
         OFS_WARN:     rd_mux = {WARN_TAG, warn_q};
         OFS_KEY:      rd_mux = {15'h0, unlocked_q};
         default:      rd_mux = 16'h0000;
      endcase
   end

   // Registered read answer, one cycle after the read strobe
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         REG_RDATA  <= 16'h0000;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RE;
         REG_RDATA  <= REG_RE ? rd_mux : 16'h0000;
      end
   end

   // Checks
   sequence s_wr_launch;
      REG_WE && REG_ADDR == OFS_WR_CTRL && REG_WDATA[START_BIT] && !wip && !rip;
   endsequence
   sequence s_act_launch;
      act_start;
   endsequence

   property p_wr_start;
      @(posedge REF_CLK) disable iff (SRST)
      s_wr_launch |=> wip && !wdn_q;
   endproperty
   a_wr_start: assert property (p_wr_start)
      else $error("write start did not set busy and clear done");

   property p_wr_finish;
      @(posedge REF_CLK) disable iff (SRST)
      $fell(wip) |-> wdn_q ##1 (wdn_q || wip);
   endproperty
   a_wr_finish: assert property (p_wr_finish)
      else $error("write done not raised and held at finish");

   // Done may only drop at the edge where a new write starts
   property p_wdn_hold;
      @(posedge REF_CLK) disable iff (SRST)
      $fell(wdn_q) |-> $rose(wip);
   endproperty
   a_wdn_hold: assert property (p_wdn_hold)
      else $error("write done dropped without a new write start");

   property p_rd_start;
      @(posedge REF_CLK) disable iff (SRST)
      (REG_WE && REG_ADDR == OFS_RD_CTRL && REG_WDATA[START_BIT] && !wip && !rip)
      |=> rip && !rdn_q ##[1:600] rdn_q;
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read start not followed by busy then done");

   property p_parity;
      @(posedge REF_CLK) disable iff (SRST)
      (REG_RE && REG_ADDR == OFS_POSITION) |=> REG_RVALID && (^REG_RDATA);
   endproperty
   a_parity: assert property (p_parity)
      else $error("position word weight is even");

   property p_cmd_reads;
      @(posedge REF_CLK) disable iff (SRST)
      (REG_RE && REG_ADDR == OFS_COMMAND) |=> REG_RDATA[11:0] == 12'h000;
   endproperty
   a_cmd_reads: assert property (p_cmd_reads)
      else $error("write-only field read back nonzero");

   property p_start_reads;
      @(posedge REF_CLK) disable iff (SRST)
      (REG_RE && (REG_ADDR == OFS_WR_CTRL || REG_ADDR == OFS_RD_CTRL))
      |=> !REG_RDATA[START_BIT];
   endproperty
   a_start_reads: assert property (p_start_reads)
      else $error("start bit read back nonzero");

   property p_locked_reload;
      @(posedge REF_CLK) disable iff (SRST)
      (REG_WE && REG_ADDR == OFS_COMMAND && !unlocked_q && !act_busy &&
       (spec_req == ACT_RELOAD || spec_req == ACT_HRESET))
      |=> !act_busy && $stable(sdn_q);
   endproperty
   a_locked_reload: assert property (p_locked_reload)
      else $error("locked part launched reload or hard reset");

   property p_sdn_cycle;
      @(posedge REF_CLK) disable iff (SRST)
      s_act_launch |=> !sdn_q && special_q != ACT_NONE ##[1:1000] sdn_q;
   endproperty
   a_sdn_cycle: assert property (p_sdn_cycle)
      else $error("action complete flag did not drop then rise");

   property p_overrun;
      @(posedge REF_CLK) disable iff (SRST)
      overrun |=> warn_q[W_BSY];
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun warning not latched");

   property p_locked_write;
      @(posedge REF_CLK) disable iff (SRST)
      s_wr_launch ##0 !unlocked_q |=> wip ##1 warn_q[W_XEE];
   endproperty
   a_locked_write: assert property (p_locked_write)
      else $error("locked write did not raise execute warning");

endmodule // sensor_host_register_bank

// ==== sensor_regs_pkg.sv ====
// Register map, field layout and timing constants of the sensor register bank
package sensor_regs_pkg;

   // Byte offsets of the host-visible 16-bit words
   localparam logic [5:0] OFS_WR_ADDR  = 6'h02;
   localparam logic [5:0] OFS_WR_UPPER = 6'h04;
   localparam logic [5:0] OFS_WR_LOWER = 6'h06;
   localparam logic [5:0] OFS_WR_CTRL  = 6'h08;
   localparam logic [5:0] OFS_RD_ADDR  = 6'h0a;
   localparam logic [5:0] OFS_RD_CTRL  = 6'h0c;
   localparam logic [5:0] OFS_RD_UPPER = 6'h0e;
   localparam logic [5:0] OFS_RD_LOWER = 6'h10;
   localparam logic [5:0] OFS_COMMAND  = 6'h1e;
   localparam logic [5:0] OFS_POSITION = 6'h20;
   localparam logic [5:0] OFS_COND     = 6'h22;
   localparam logic [5:0] OFS_FAULT    = 6'h24;
   localparam logic [5:0] OFS_WARN     = 6'h26;
   localparam logic [5:0] OFS_KEY      = 6'h3c;

   // Bit positions
   localparam int START_BIT   = 15;  // write/read start, write-only
   localparam int BUSY_BIT    = 8;   // write/read in progress
   localparam int DONE_BIT    = 0;   // write/read finished
   localparam int CLR_FAULT   = 8;
   localparam int CLR_WARN    = 9;
   localparam int CLR_STATUS  = 10;
   localparam int SPECIAL_LSB = 12;
   localparam int PAR_BIT     = 12;
   localparam int UV_BIT      = 13;
   localparam int SUM_BIT     = 14;
   localparam int F_RST       = 0;
   localparam int F_UVA       = 2;
   localparam int F_UVD       = 3;
   localparam int F_WAR       = 11;
   localparam int W_BSY       = 2;
   localparam int W_XEE       = 7;
   localparam int KEY_LSB     = 8;

   // Fixed identifier bits in the upper nibble of some words
   localparam logic [3:0] COND_TAG  = 4'h8;
   localparam logic [3:0] FAULT_TAG = 4'ha;
   localparam logic [3:0] WARN_TAG  = 4'hb;

   // Latched fault bits fed by events (rst and uv handled apart)
   localparam logic [10:0] FAULT_EV_MASK = 11'h7f2;
   localparam logic [10:0] FAULT_RST_VAL = 11'h001;
   // Warning bits that exist in the warning word
   localparam logic [11:0] WARN_EV_MASK  = 12'hdf6;

   // Trigger codes
   localparam logic [7:0] TRIG_SELFTEST = 8'hb9;
   localparam logic [7:0] TRIG_NVM      = 8'ha5;
   localparam logic [7:0] TRIG_RESET    = 8'h5a;

   // Special action codes
   typedef enum logic [3:0] {
      ACT_NONE   = 4'h0,
      ACT_MARGLO = 4'h1,
      ACT_MARGHI = 4'h2,
      ACT_RELOAD = 4'h5,
      ACT_HRESET = 4'h7,
      ACT_FE_ST  = 4'h9,
      ACT_LOG_ST = 4'ha,
      ACT_BOTH   = 4'hb
   } action_t;

   // Unlock key sequence
   localparam int KEY_LEN = 5;
   function automatic logic [7:0] key_code(input logic [2:0] step);
      case (step)
         3'd0:    key_code = 8'h00;
         3'd1:    key_code = 8'h27;
         3'd2:    key_code = 8'h81;
         3'd3:    key_code = 8'h1f;
         default: key_code = 8'h77;
      endcase
   endfunction

   // Timing
   localparam int CLK_KHZ        = 250000;
   localparam int NVM_WR_TIME_MS = 24;
   localparam int NVM_RD_TIME_NS = 2000;
   localparam int NVM_WR_CYC_DEF = NVM_WR_TIME_MS * CLK_KHZ;
   localparam int NVM_RD_CYC     = (NVM_RD_TIME_NS * (CLK_KHZ / 1000)) / 1000;
   localparam int SHADOW_CYC     = 1;
   localparam int ACTION_CYC_DEF = 64;
   localparam int TMR_W          = 24;

   // Read address value left after reload, logic self-test or combined self-test
   localparam logic [7:0] RD_ADDR_AFTER = 8'h00;

endpackage

// ==== xfer_timer.sv ====
// Down-counter that times one extended access or special action
module xfer_timer #(
   parameter int W = 24
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Launch
   input  wire logic         start,
   input  wire logic [W-1:0] len,
   // State
   output logic              busy,
   output logic              done
);

   logic [W-1:0] cnt_q;  // Cycles left minus one

   // Load on start, count down while busy; a zero length acts as one
   always_ff @(posedge clk) begin
      if (rst) begin
         busy  <= 1'b0;
         cnt_q <= '0;
      end else if (start) begin
         busy  <= 1'b1;
         cnt_q <= (len == '0) ? '0 : len - W'(1);
      end else if (busy) begin
         if (cnt_q == '0) begin
            busy <= 1'b0;
         end else begin
            cnt_q <= cnt_q - W'(1);
         end
      end
   end

   // Final cycle of the run
   assign done = busy && (cnt_q == '0) && !start;

endmodule // xfer_timer

// ==== sensor_host_model.sv ====
// Host controller model that drives the register port
module sensor_host_model (
   // Clock
   input  wire logic        clk,
   // Register port
   output logic      [5:0]  addr,
   output logic             we,
   output logic             re,
   output logic      [15:0] wdata,
   input  wire logic [15:0] rdata,
   input  wire logic        rvalid
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle port at time zero
   initial begin
      addr = 6'h00;
      we = 1'b0;
      re = 1'b0;
      wdata = 16'h0000;
   end

   // One strobe, held to the taking edge; leading edge wait stops re-entry
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 addr = a;
      wdata = d;
      we = 1'b1;
      @(posedge clk);
      #1 we = 1'b0;
      // Stale data is inverted so nothing relies on a held bus
      wdata = ~d;
   endtask

   // Read strobe; answer is registered and stands one cycle
   task automatic rd(input logic [5:0] a, output logic [15:0] d,
                     output logic v);
      @(posedge clk);
      #1 addr = a;
      re = 1'b1;
      @(posedge clk);
      #1 re = 1'b0;
      d = rdata;
      v = rvalid;
   endtask
endmodule // sensor_host_model

// ==== sensor_host_register_bank_tb_top.sv ====
// Register-level testbench of the sensor host register bank
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module sensor_host_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sensor_regs_pkg::*;

   logic        clk = 1'b0;   // 250 MHz clock
   logic        srst = 1'b1;  // Synchronous reset
   logic [11:0] angle = 12'h123;
   logic        uva = 1'b0;   // Analog undervoltage level
   logic        boot_busy = 1'b1;  // Boot running out of reset
   logic        boot_done = 1'b0;  // Boot completion pulse
   logic [15:0] ev = 16'h0;   // Events and masks kept quiet
   logic [5:0]  addr;
   logic        we, re, rvalid;
   logic [15:0] wdata, rdata;
   int          n_fail = 0;
   int          comparisons = 0;
   logic [7:0]  keys [5] = '{8'h00, 8'h27, 8'h81, 8'h1f, 8'h77};

   always #2 clk = ~clk;

   sensor_host_register_bank #(.NVM_WR_CYC(20), .ACTION_CYC(8))
   i_sensor_host_register_bank (.REF_CLK(clk), .SRST(srst),
      .REG_ADDR(addr), .REG_WE(we), .REG_RE(re), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .ANGLE(angle),
      .PLL_LOCK(1'b1), .ROT_DIR(1'b1), .DIE_ID(2'b10),
      .BOOT_BUSY(boot_busy), .BOOT_DONE(boot_done), .UV_ANALOG(uva),
      .UV_DIGITAL(ev[1]),
      .NVM_WRITE_FAIL(ev[0]), .FAULT_EVENTS(ev), .WARN_EVENTS(ev),
      .ERR_MASK(ev), .WARN_MASK(ev));

   sensor_host_model i_sensor_host_model (.clk(clk), .addr(addr), .we(we),
      .re(re), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

   // Read a word and compare it together with its valid flag
   task automatic expect_rd(input logic [5:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic        v;
      i_sensor_host_model.rd(a, d, v);
      `CHK({v, d}, {1'b1, e})
   endtask

   // Print counts and the verdict, then stop
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      #1 srst = 1'b0;
      expect_rd(OFS_COND, 16'h8283);
      // Boot ends with a one-cycle completion pulse
      boot_busy = 1'b0;
      boot_done = 1'b1;
      @(posedge clk);
      #1 boot_done = 1'b0;
      expect_rd(OFS_FAULT, 16'ha001);
      i_sensor_host_model.wr(OFS_COMMAND, 16'h0100);
      expect_rd(OFS_FAULT, 16'ha000);
      expect_rd(OFS_POSITION, 16'h1123);
      uva = 1'b1;
      expect_rd(OFS_POSITION, 16'h7123);
      uva = 1'b0;
      expect_rd(OFS_FAULT, 16'ha004);
      // Locked shadow write must fail with the execute warning
      i_sensor_host_model.wr(OFS_WR_ADDR, 16'h0040);
      i_sensor_host_model.wr(OFS_WR_CTRL, 16'h8000);
      repeat (3) @(posedge clk);
      expect_rd(OFS_WARN, 16'hb080);
      i_sensor_host_model.wr(OFS_COMMAND, 16'h0200);
      expect_rd(OFS_WARN, 16'hb000);
      for (int i = 0; i < 5; i++)
         i_sensor_host_model.wr(OFS_KEY, {keys[i], 8'h00});
      expect_rd(OFS_KEY, 16'h0001);
      // both payload halves before the start
      i_sensor_host_model.wr(OFS_WR_UPPER, 16'hbeef);
      i_sensor_host_model.wr(OFS_WR_LOWER, 16'h1234);
      i_sensor_host_model.wr(OFS_WR_CTRL, 16'h8000);
      repeat (3) @(posedge clk);
      expect_rd(OFS_WR_CTRL, 16'h0001);
      i_sensor_host_model.wr(OFS_RD_ADDR, 16'h0040);
      i_sensor_host_model.wr(OFS_RD_CTRL, 16'h8000);
      repeat (3) @(posedge clk);
      expect_rd(OFS_RD_CTRL, 16'h0001);
      expect_rd(OFS_RD_UPPER, 16'hbeef);
      expect_rd(OFS_RD_LOWER, 16'h1234);
      // Memory write runs long; a read start meanwhile is an overrun
      i_sensor_host_model.wr(OFS_WR_ADDR, 16'h0000);
      i_sensor_host_model.wr(OFS_WR_CTRL, 16'h8000);
      expect_rd(OFS_WR_CTRL, 16'h0100);
      i_sensor_host_model.wr(OFS_RD_CTRL, 16'h8000);
      expect_rd(OFS_WARN, 16'hb004);
      repeat (30) @(posedge clk);
      expect_rd(OFS_WR_CTRL, 16'h0001);
      i_sensor_host_model.wr(OFS_COMMAND, 16'hb0b9);
      expect_rd(OFS_COND, 16'h829d);
      repeat (12) @(posedge clk);
      expect_rd(OFS_COND, 16'h82b1);
      expect_rd(OFS_COMMAND, 16'h0000);
      expect_rd(OFS_RD_ADDR, 16'h0000);
      i_sensor_host_model.wr(OFS_COMMAND, 16'hb0a5);
      expect_rd(OFS_COND, 16'h82b1);
      i_sensor_host_model.wr(OFS_COMMAND, 16'h0400);
      expect_rd(OFS_COND, 16'h8281);
      i_sensor_host_model.wr(OFS_COMMAND, 16'h705a);
      repeat (12) @(posedge clk);
      // Overrun warning and old undervoltage stay latched across it
      expect_rd(OFS_FAULT, 16'ha805);
      // Hard reset relocked the part, so a reload must not start
      i_sensor_host_model.wr(OFS_COMMAND, 16'h50a5);
      expect_rd(OFS_COND, 16'h82a1);
      give_verdict();
   end
endmodule // sensor_host_register_bank_tb_top
